// >>> mic_core_model.sv
// Behavioural model of the core sequencer facing the interrupt block.
// Assumes it shares hclk and that the bench asks for returns via ret_req.
`timescale 1ns/1ps

module mic_core_model
   import mic_pkg::*;
(
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // Bench side.
   input wire logic ret_req,
   // Block side.
   input wire logic pc_load,
   input wire logic [PC_W-1:0] pc_next,
   output logic return_from_interrupt,
   output logic [PC_W-1:0] pc_now,
   output mic_ctx_t ctx_in
);
   // The counter walks every cycle, so a stale push shows up on return.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pc_now <= 15'h0100;
      end else if (pc_load) begin
         pc_now <= pc_next;
      end else begin
         pc_now <= pc_now + 15'h0001;
      end
   end

   // One return pulse for each request, as a single instruction gives.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         return_from_interrupt <= 1'b0;
      end else begin
         return_from_interrupt <= ret_req;
      end
   end

   // Context follows the counter so that every entry saves a new value.
   assign ctx_in = {pc_now[7:0], 5'h15, 5'h0A, pc_now[14:8]};
endmodule : mic_core_model

// >>> mic_ctrl.sv
// Interrupt control block: flags, enables, entry and return sequencing,
// AHB-Lite register slave and a sticky event interrupt output.
// Assumes the core sequencer runs on hclk, holds insn_hold for at most one
// cycle, and pulses return_from_interrupt once per return instruction.
`timescale 1ns/1ps

module mic_ctrl
   import mic_pkg::*;
(
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Event sources.
   input wire logic timer_zero_evt,
   input wire logic ext_pin,
   input wire logic pin_change,
   input wire logic [2:0][7:0] per_evt,
   // Core sequencer.
   input wire logic insn_hold,
   input wire logic return_from_interrupt,
   input wire logic [PC_W-1:0] pc_now,
   input wire mic_ctx_t ctx_in,
   output logic prefetch_flush,
   output logic pc_load,
   output logic [PC_W-1:0] pc_next,
   output logic ctx_restore,
   output mic_ctx_t ctx_out,
   output logic global_irq_enable,
   output logic irq
);

   typedef enum {ST_IDLE, ST_ENTER, ST_RETURN} mic_state_t;

   mic_state_t state;
   logic [7:0] control;
   logic [7:0] req [3];
   logic [7:0] en [3];
   logic [EVT_W-1:0] evt_stat;
   logic [EVT_W-1:0] evt_mask;
   logic ph_valid;
   logic ph_write;
   logic ph_word;
   logic [11:0] ph_idx;
   logic wr_go;
   logic [7:0] rd_val;
   logic [1:0] pins_sync;
   logic [1:0] pins_last;
   logic ext_set;
   logic pch_set;
   logic pending;
   logic take;
   logic pop;
   logic ret_done;
   logic [PC_W-1:0] top_pc;
   logic stack_ovf;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------

   // Software write merged with hardware sets; a set beats a clear.
   function automatic logic [7:0] upd(input logic [7:0] cur,
                                     input logic wr,
                                     input logic [7:0] wd,
                                     input logic [7:0] set,
                                     input logic [7:0] impl);
      upd = ((wr ? wd : cur) | set) & impl;
   endfunction : upd

   // Bit 1 of the second group is not implemented and reads zero.
   function automatic logic [7:0] impl_of(input int i);
      impl_of = (i == 1) ? GRP2_IMPL : FULL_IMPL;
   endfunction : impl_of

   // ----------------------------------------------------------------
   // AHB-Lite slave
   // ----------------------------------------------------------------

   // Every transfer gets one wait state so reads see earlier writes.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_valid <= 1'b0;
         ph_write <= 1'b0;
         ph_word <= 1'b0;
         ph_idx <= '0;
         hreadyout <= 1'b1;
      end else if (hsel && htrans[1] && hready) begin
         ph_valid <= 1'b1;
         ph_write <= hwrite;
         ph_word <= (hsize == WORD_SIZE);
         ph_idx <= haddr[13:2];
         hreadyout <= 1'b0;
      end else begin
         ph_valid <= 1'b0;
         hreadyout <= 1'b1;
      end
   end

   // Only whole-word writes change registers; others are ignored.
   assign wr_go = ph_valid && ph_write && ph_word;

   // The response is always OKAY.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
      end
   end

   // Read multiplexer; unmapped indexes read zero.
   always_comb begin
      rd_val = 8'h00;
      case (ph_idx)
         IDX_CONTROL: rd_val = control;
         IDX_REQ1: rd_val = req[0];
         IDX_REQ2: rd_val = req[1];
         IDX_REQ3: rd_val = req[2];
         IDX_EN1: rd_val = en[0];
         IDX_EN2: rd_val = en[1];
         IDX_EN3: rd_val = en[2];
         IDX_EVT_STAT: rd_val = {5'h00, evt_stat};
         IDX_EVT_MASK: rd_val = {5'h00, evt_mask};
         default: rd_val = 8'h00;
      endcase
   end

   // Read data is captured in the wait cycle and held afterwards.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= '0;
      end else if (ph_valid && !ph_write) begin
         hrdata <= {24'h000000, rd_val};
      end
   end

   // ----------------------------------------------------------------
   // Event capture
   // ----------------------------------------------------------------

   mic_sync #(
      .W(2)
   ) u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .din({pin_change, ext_pin}),
      .dout(pins_sync)
   );

   // Edge detection works on synchronised levels only.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pins_last <= 2'h0;
      end else begin
         pins_last <= pins_sync;
      end
   end

   // The pin event is a rising edge; a pin change is either edge.
   assign ext_set = pins_sync[0] && !pins_last[0];
   assign pch_set = pins_sync[1] ^ pins_last[1];

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------

   // Hardware GLOBAL_IRQ_ENABLE updates override a bus write in the same cycle so an
   // entry can never be undone by software racing it.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         control <= CONTROL_RST;
      end else begin
         control <= upd(control, wr_go && ph_idx == IDX_CONTROL,
                        hwdata[7:0],
                        {5'h00, timer_zero_evt, ext_set, pch_set},
                        FULL_IMPL);
         if (take) begin
            control[GIE_BIT] <= 1'b0;
         end else if (ret_done) begin
            control[GIE_BIT] <= 1'b1;
         end
      end
   end

   assign global_irq_enable = control[GIE_BIT];

   // ----------------------------------------------------------------
   // Peripheral request and enable groups
   // ----------------------------------------------------------------

   // Request flags follow their events regardless of any enable.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < 3; i++) begin
            req[i] <= GROUP_RST;
         end
      end else begin
         for (int i = 0; i < 3; i++) begin
            req[i] <= upd(req[i],
                          wr_go && ph_idx == IDX_REQ1 + 12'(i),
                          hwdata[7:0], per_evt[i], impl_of(i));
         end
      end
   end

   // Enables are plain software bits.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < 3; i++) begin
            en[i] <= GROUP_RST;
         end
      end else begin
         for (int i = 0; i < 3; i++) begin
            en[i] <= upd(en[i], wr_go && ph_idx == IDX_EN1 + 12'(i),
                         hwdata[7:0], 8'h00, impl_of(i));
         end
      end
   end

   // ----------------------------------------------------------------
   // Entry and return sequencing
   // ----------------------------------------------------------------

   // A source counts only with its own enable; peripheral groups also
   // need the group enable.
   assign pending = (|(control[T0_EN_BIT:PCH_EN_BIT]
                       & control[T0_FLAG_BIT:0]))
                    || (control[PERIPHERAL_GROUP_ENABLE_BIT]
                        && |((req[0] & en[0]) | (req[1] & en[1])
                             | (req[2] & en[2])));

   // A return instruction in flight has priority over a new entry.
   assign take = (state == ST_IDLE) && control[GIE_BIT] && pending
                 && !insn_hold && !return_from_interrupt;
   assign pop = (state == ST_IDLE) && return_from_interrupt;
   assign ret_done = (state == ST_RETURN);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE: begin
               if (pop) begin
                  state <= ST_RETURN;
               end else if (take) begin
                  state <= ST_ENTER;
               end
            end
            ST_ENTER: state <= ST_IDLE;
            ST_RETURN: state <= ST_IDLE;
            default: state <= ST_IDLE;
         endcase
      end
   end

   mic_stack u_stack (
      .hclk(hclk),
      .hresetn(hresetn),
      .push(take),
      .pop(pop),
      .push_pc(pc_now),
      .top_pc(top_pc),
      .overflow(stack_ovf)
   );

   // Context is shadowed in the same cycle the entry is taken.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctx_out <= '0;
      end else if (take) begin
         ctx_out <= ctx_in;
      end
   end

   // Core strobes: flush at entry, vector a cycle later, or restore.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prefetch_flush <= 1'b0;
         pc_load <= 1'b0;
         pc_next <= '0;
         ctx_restore <= 1'b0;
      end else begin
         prefetch_flush <= take;
         pc_load <= (state == ST_ENTER) || ret_done;
         ctx_restore <= ret_done;
         if (state == ST_ENTER) begin
            pc_next <= VECTOR_ADDR;
         end else if (ret_done) begin
            pc_next <= top_pc;
         end
      end
   end

   // ----------------------------------------------------------------
   // Event status, mask and interrupt output
   // ----------------------------------------------------------------

   // Write one to clear; an event in the same cycle keeps its bit.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         evt_stat <= EVT_RST;
         evt_mask <= EVT_RST;
      end else begin
         evt_stat <= (evt_stat
                      & ~((wr_go && ph_idx == IDX_EVT_STAT)
                          ? hwdata[EVT_W-1:0] : EVT_RST))
                     | {stack_ovf, ret_done, take};
         if (wr_go && ph_idx == IDX_EVT_MASK) begin
            evt_mask <= hwdata[EVT_W-1:0];
         end
      end
   end

   // The output trails the status by one cycle, which keeps it a flop.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(evt_stat & evt_mask);
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence s_entry;
      ##1 prefetch_flush && !global_irq_enable
      ##1 pc_load && pc_next == VECTOR_ADDR;
   endsequence

   sequence s_sync_evt;
      timer_zero_evt && state == ST_IDLE && global_irq_enable
      && control[T0_EN_BIT] && !pending
      ##1 !insn_hold && !return_from_interrupt;
   endsequence

   sequence s_async_evt;
      $rose(ext_pin) && state == ST_IDLE && global_irq_enable
      && control[EXT_EN_BIT] && !pending
      ##3 !insn_hold && !return_from_interrupt && global_irq_enable
      && state == ST_IDLE;
   endsequence

   property p_gie_rise;
      $rose(global_irq_enable) |->
         $past(ret_done) || $past(wr_go && ph_idx == IDX_CONTROL);
   endproperty
   a_gie_rise: assert property (p_gie_rise)
      else $error("global enable rose without return or write");

   property p_take_cause;
      prefetch_flush |-> $past(global_irq_enable) && $past(pending);
   endproperty
   a_take_cause: assert property (p_take_cause)
      else $error("entry without enabled pending source");

   property p_flag_set;
      timer_zero_evt && per_evt[0][0] |=>
         control[T0_FLAG_BIT] && req[0][0];
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("event did not set its flag");

   property p_group_flag;
      per_evt[2][7] && !control[PERIPHERAL_GROUP_ENABLE_BIT] |=> req[2][7];
   endproperty
   a_group_flag: assert property (p_group_flag)
      else $error("request flag lost while group disabled");

   property p_entry;
      take |-> s_entry;
   endproperty
   a_entry: assert property (p_entry)
      else $error("entry did not flush then load the vector");

   property p_shadow;
      take |=> ctx_out == $past(ctx_in);
   endproperty
   a_shadow: assert property (p_shadow)
      else $error("context not shadowed on entry");

   // Judged in the cycle of the decision: a write that sets the global
   // enable may legally be followed by an entry in the very next cycle.
   property p_masked;
      !global_irq_enable |-> !take;
   endproperty
   a_masked: assert property (p_masked)
      else $error("redirect while global enable clear");

   property p_return;
      pop |-> ##2 pc_load && ctx_restore && global_irq_enable;
   endproperty
   a_return: assert property (p_return)
      else $error("return did not restore and re-enable");

   property p_sync_latency;
      s_sync_evt |-> ##2 pc_load && pc_next == VECTOR_ADDR;
   endproperty
   a_sync_latency: assert property (p_sync_latency)
      else $error("synchronous latency not three cycles");

   property p_async_latency;
      s_async_evt |-> ##2 pc_load && pc_next == VECTOR_ADDR;
   endproperty
   a_async_latency: assert property (p_async_latency)
      else $error("asynchronous latency not five cycles");

   property p_grp2_bit1;
      en[1][1] == 1'b0 && req[1][1] == 1'b0;
   endproperty
   a_grp2_bit1: assert property (p_grp2_bit1)
      else $error("unimplemented group two bit set");

endmodule : mic_ctrl

// >>> mic_pkg.sv
// Constants and types shared by the interrupt control block.
// Assumes one instruction clock for the block, the core sequencer and
// every synchronous event source.
// Operation
// - Any reset leaves all interrupts disabled until software enables them.
// - Redirect needs global enable, own enable, and group enable for peripherals.
// - Control and three request registers keep one flag per source.
// - Flags set on their event whatever the enable bits say.
// - Taking an interrupt flushes the prefetch and clears the global enable.
// - Taking an interrupt pushes the current program counter on the stack; with 16 entries held the push is dropped.
// - Taking an interrupt copies core context into shadow registers.
// - After saving state the program counter loads the fixed vector.
// - With global enable clear flags still set; service waits for enable.
// - Return pops the address, restores context and sets global enable.
// - Synchronous sources reach the vector three or four cycles later.
// - Asynchronous sources reach the vector five or six cycles later.
// - Second peripheral enable register layout, bit 1 reads zero, resets zero.

package mic_pkg;

   // ----------------------------------------------------------------
   // Register indexes; the byte address is four times the index.
   // ----------------------------------------------------------------
   localparam logic [11:0] IDX_CONTROL = 12'h78B;
   localparam logic [11:0] IDX_REQ1 = 12'h7C0;
   localparam logic [11:0] IDX_REQ2 = 12'h7C1;
   localparam logic [11:0] IDX_REQ3 = 12'h7C2;
   localparam logic [11:0] IDX_EN1 = 12'h7C3;
   localparam logic [11:0] IDX_EN2 = 12'h7C4;
   localparam logic [11:0] IDX_EN3 = 12'h7C5;
   localparam logic [11:0] IDX_EVT_STAT = 12'h7C6;
   localparam logic [11:0] IDX_EVT_MASK = 12'h7C7;

   // ----------------------------------------------------------------
   // Field positions and reset values.
   // ----------------------------------------------------------------
   localparam int GIE_BIT = 7;
   localparam int PERIPHERAL_GROUP_ENABLE_BIT = 6;
   localparam int T0_EN_BIT = 5;
   localparam int EXT_EN_BIT = 4;
   localparam int PCH_EN_BIT = 3;
   localparam int T0_FLAG_BIT = 2;
   localparam logic [7:0] CONTROL_RST = 8'h00;
   localparam logic [7:0] GROUP_RST = 8'h00;
   localparam logic [7:0] GRP2_IMPL = 8'hFD;
   localparam logic [7:0] FULL_IMPL = 8'hFF;
   localparam logic [2:0] WORD_SIZE = 3'h2;

   // ----------------------------------------------------------------
   // Core side.
   // ----------------------------------------------------------------
   localparam int PC_W = 15;
   localparam logic [PC_W-1:0] VECTOR_ADDR = 15'h0004;
   localparam int STACK_DEPTH = 16;
   localparam int STACK_PTR_W = 5;
   localparam int EVT_W = 3;
   localparam logic [EVT_W-1:0] EVT_RST = 3'h0;

   // Core context saved on entry and restored on return.
   typedef struct packed {
      logic [7:0] wreg;
      logic [4:0] status;
      logic [4:0] bsr;
      logic [6:0] pclath;
   } mic_ctx_t;

endpackage : mic_pkg

// >>> mic_stack.sv
// Hardware return stack for program counter values.
// Assumes push and pop are never requested in the same cycle.
`timescale 1ns/1ps

module mic_stack
   import mic_pkg::*;
(
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // Requests.
   input wire logic push,
   input wire logic pop,
   input wire logic [PC_W-1:0] push_pc,
   // Results.
   output logic [PC_W-1:0] top_pc,
   output logic overflow
);

   logic [PC_W-1:0] mem [STACK_DEPTH];
   logic [STACK_PTR_W-1:0] ptr;
   logic full;

   assign full = (ptr == STACK_PTR_W'(STACK_DEPTH));

   // A push into a full stack is dropped rather than overwriting.
   always_ff @(posedge hclk) begin
      if (push && !full) begin
         mem[ptr[STACK_PTR_W-2:0]] <= push_pc;
      end
   end

   // Pointer, registered read data and overflow pulse.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ptr <= '0;
         top_pc <= '0;
         overflow <= 1'b0;
      end else begin
         overflow <= push && full;
         if (push && !full) begin
            ptr <= ptr + 1'b1;
         end else if (pop && ptr != '0) begin
            ptr <= ptr - 1'b1;
            top_pc <= mem[ptr[STACK_PTR_W-2:0] - 1'b1];
         end
      end
   end

   property p_push_ptr;
      @(posedge hclk) disable iff (!hresetn)
      push && !full |=> ptr == $past(ptr) + 1'b1;
   endproperty
   a_push_ptr: assert property (p_push_ptr)
      else $error("stack pointer did not advance on push");

endmodule : mic_stack

// >>> mic_sync.sv
// Two-stage synchroniser for asynchronous event pins.
// Assumes the inputs may change at any time relative to hclk.
`timescale 1ns/1ps

module mic_sync #(
   parameter int W = 2
) (
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // Levels.
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);

   logic [W-1:0] meta;

   // The first stage feeds only the second stage.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta <= '0;
         dout <= '0;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end

endmodule : mic_sync

// >>> tb.sv
// Self-checking bench for the interrupt control block.
// Assumes hready loops back from hreadyout and one core model.
`timescale 1ns/1ps

module tb
   import mic_pkg::*;
;
   typedef struct packed {
      logic [11:0] idx;
      logic [7:0] wd;
      logic [7:0] exp;
   } mic_row_t;
   localparam mic_row_t ROWS [8] = '{'{IDX_REQ1, 8'hA5, 8'hA5},
      '{IDX_REQ2, 8'hFF, 8'hFD}, '{IDX_REQ3, 8'h5A, 8'h5A},
      '{IDX_EN1, 8'hFF, 8'hFF}, '{IDX_EN2, 8'hFF, 8'hFD},
      '{IDX_EN3, 8'h3C, 8'h3C}, '{IDX_CONTROL, 8'h7F, 8'h7F},
      '{12'h7D0, 8'hFF, 8'h00}};
   logic hclk = 0;
   logic hresetn = 0;
   logic hsel = 0;
   logic [31:0] haddr = 0;
   logic [1:0] htrans = 0;
   logic hwrite = 0;
   logic [2:0] hsize = WORD_SIZE;
   logic [31:0] hwdata = 0;
   logic hreadyout, hresp, prefetch_flush, pc_load, ctx_restore, irq;
   logic [31:0] hrdata, rdata;
   logic timer_zero_evt = 0, ext_pin = 0, pin_change = 0;
   logic [2:0][7:0] per_evt = '0;
   logic insn_hold = 0, hold_arm = 0, ret_req = 0, rfi, global_irq_enable;
   logic [PC_W-1:0] pc_now, pc_next, spc;
   mic_ctx_t ctx_in, ctx_out, sctx;
   logic pf;
   int n, ents = 0, cycles = 0, bad_count = 0, compares = 0;

   mic_ctrl uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
      .timer_zero_evt, .ext_pin, .pin_change, .per_evt, .insn_hold,
      .return_from_interrupt(rfi), .pc_now, .ctx_in, .prefetch_flush,
      .pc_load, .pc_next, .ctx_restore, .ctx_out, .global_irq_enable, .irq);
   mic_core_model model (.hclk, .hresetn, .ret_req, .pc_load, .pc_next,
      .return_from_interrupt(rfi), .pc_now, .ctx_in);

   always #5 hclk = ~hclk;

   // Strobes drop after one cycle; the hold lags its arm by one cycle.
   always @(posedge hclk) begin
      cycles++;
      if (prefetch_flush === 1'b1) ents++;
      if (timer_zero_evt) timer_zero_evt <= 1'b0;
      if (ret_req) ret_req <= 1'b0;
      if (hold_arm) hold_arm <= 1'b0;
      if (|per_evt) per_evt <= '0;
      insn_hold <= hold_arm;
      if (cycles == 3000) begin
         bad_count++;
         final_report();
      end
   end

   task chk(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         bad_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk

   // Called just after a rising edge; waits on hready, never a fixed count.
   task ahb(input logic w, input logic [11:0] idx, input logic [7:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {18'h0, idx, 2'h0};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rdata = hrdata;
   endtask : ahb

   task rdchk(input logic [11:0] idx, input logic [7:0] e);
      ahb(1'b0, idx, 8'h00);
      chk(rdata, {24'h0, e});
   endtask : rdchk

   // Cycles from the event cycle to the vector load; saves the state one cycle after the event cycle.
   task lat(output int k);
      k = 0;
      pf = 0;
      @(negedge hclk);
      while (pc_load !== 1'b1 && k < 20) begin
         k++;
         @(negedge hclk);
         if (prefetch_flush === 1'b1) pf = 1;
         if (k == 1) begin
            spc = pc_now;
            sctx = ctx_in;
         end
      end
   endtask : lat

   // Service routine tail: rewrite control, then return from interrupt.
   task svc(input logic [7:0] ctl);
      int i;
      @(posedge hclk);
      ahb(1'b1, IDX_CONTROL, ctl);
      ret_req <= 1'b1;
      i = 0;
      while (ctx_restore !== 1'b1 && i < 20) begin
         @(negedge hclk);
         i++;
      end
      @(posedge hclk);
   endtask : svc

   task final_report();
      $display("compares=%0d bad_count=%0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : final_report

   // Main sequence: register rows first, then hand-written cases.
   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      foreach (ROWS[i]) begin
         rdchk(ROWS[i].idx, 8'h00);
         ahb(1'b1, ROWS[i].idx, ROWS[i].wd);
         rdchk(ROWS[i].idx, ROWS[i].exp);
         ahb(1'b1, ROWS[i].idx, 8'h00);
      end
      $display("test registers done");
      ahb(1'b1, IDX_CONTROL, 8'h20);
      timer_zero_evt <= 1'b1;
      repeat (8) @(posedge hclk);
      chk(ents, 0);
      rdchk(IDX_CONTROL, 8'h24);
      ahb(1'b1, IDX_CONTROL, 8'hA4);
      repeat (6) @(negedge hclk);
      chk(ents, 1);
      chk(pc_next, VECTOR_ADDR);
      chk(global_irq_enable, 1'b0);
      svc(8'h20);
      chk(global_irq_enable, 1'b1);
      $display("test pending done");
      timer_zero_evt <= 1'b1;
      lat(n);
      chk(n, 3);
      chk(pf, 1'b1);
      chk(ctx_out, sctx);
      svc(8'h20);
      chk(pc_next, spc);
      hold_arm <= 1'b1;
      timer_zero_evt <= 1'b1;
      lat(n);
      chk(n, 4);
      svc(8'h10);
      ext_pin <= 1'b1;
      lat(n);
      chk(n, 5);
      svc(8'h00);
      ext_pin <= 1'b0;
      $display("test latency done");
      ahb(1'b1, IDX_EN1, 8'h01);
      per_evt <= 24'h800001;
      timer_zero_evt <= 1'b1;
      repeat (8) @(posedge hclk);
      chk(ents, 4);
      rdchk(IDX_REQ1, 8'h01);
      ahb(1'b1, IDX_CONTROL, 8'hC0);
      repeat (6) @(posedge hclk);
      chk(ents, 5);
      ahb(1'b1, IDX_REQ1, 8'h00);
      svc(8'h40);
      $display("test group done");
      rdchk(IDX_EVT_STAT, 8'h03);
      chk(irq, 1'b0);
      ahb(1'b1, IDX_EVT_MASK, 8'h01);
      repeat (3) @(posedge hclk);
      chk(irq, 1'b1);
      ahb(1'b1, IDX_EVT_STAT, 8'h01);
      repeat (3) @(posedge hclk);
      chk(irq, 1'b0);
      rdchk(IDX_EVT_STAT, 8'h02);
      $display("test status done");
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      chk(global_irq_enable, 1'b0);
      rdchk(IDX_CONTROL, 8'h00);
      $display("test reset done");
      final_report();
   end
endmodule : tb
